// File: verilog/haptic_waveform_calib_regs.sv
// Haptic waveform timing and closed-loop calibration register bank
// Contract
// R1: Negative sustain offset equals value times tick
// R2: Negative levels except overdrive and brake are sustain-negative
// R3: Brake offset equals value times tick
// R4: Brake segment is the most negative level
// R5: Brake offset ignored in closed loop
// R6: Full-scale reference caps closed-loop drive, reset 63
// R7: Host loads full-scale before calibration
// R8: Host reruns calibration after full-scale change
// R9: Auto overdrive and brake may exceed full-scale
// R10: Auto overdrive and brake capped by limit
// R11: Calibration end writes loss trim, reset 13
// R12: Loss trim added to output drive
// R13: Calibration derives trim from measured impedance
// R14: Feedback gain from gain register, reset 109
// R15: Settings sampled at each playback start
`timescale 1ns/1ns
module haptic_waveform_calib_regs (
   input  wire logic                                   i_clk,
   input  wire logic                                   i_rstn,
   input  wire logic                                   i_wr_en,
   input  wire logic                                   i_rd_en,
   input  wire logic [7:0]                             i_addr,
   input  wire logic [7:0]                             i_wdata,
   input  wire logic                                   i_play_start,
   input  wire logic                                   i_closed_loop,
   input  wire logic                                   i_auto_phase,
   input  wire logic signed [7:0]                      i_level,
   input  wire logic signed [7:0]                      i_wave_max,
   input  wire logic signed [7:0]                      i_wave_min,
   input  wire logic [7:0]                             i_demand,
   input  wire logic [7:0]                             i_tick_period,
   input  wire logic                                   i_cal_done,
   input  wire logic [7:0]                             i_cal_comp,
   input  wire logic [7:0]                             i_cal_gain,
   output logic      [7:0]                             o_rdata,
   output haptic_calib_pkg::seg_kind_e                 o_seg_kind,
   output logic signed [haptic_calib_pkg::TIME_W-1:0]  o_time_adj_ms,
   output logic      [7:0]                             o_drive_level,
   output logic      [7:0]                             o_full_scale,
   output logic      [7:0]                             o_feedback_gain,
   output logic      [7:0]                             o_loss_trim
);
   import haptic_calib_pkg::*;

   // ==========================================================
   // Declarations
   logic [7:0]               neg_sustain,      next_neg_sustain;
   logic [7:0]               brake_time,       next_brake_time;
   logic [7:0]               full_scale,       next_full_scale;
   logic [7:0]               peak_limit,       next_peak_limit;
   logic [7:0]               loss_trim,        next_loss_trim;
   logic [7:0]               fb_gain,          next_fb_gain;
   logic [7:0]               snap_snt,         next_snap_snt;
   logic [7:0]               snap_brt,         next_snap_brt;
   logic [7:0]               snap_full,        next_snap_full;
   logic [7:0]               snap_limit,       next_snap_limit;
   logic [7:0]               snap_trim,        next_snap_trim;
   logic [7:0]               snap_gain,        next_snap_gain;
   logic [7:0]               next_rdata;
   seg_kind_e                next_seg_kind;
   logic signed [TIME_W-1:0] next_time_adj;
   logic [7:0]               next_drive_level;

   haptic_calc_if calc_bus ();

   // Address match used by both write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction : hit

   // ==========================================================
   // Host writes and calibration result capture
   always_comb begin
      next_neg_sustain = neg_sustain;
      next_brake_time  = brake_time;
      next_full_scale  = full_scale;
      next_peak_limit  = peak_limit;
      next_loss_trim   = loss_trim;
      next_fb_gain     = fb_gain;
      if (i_wr_en) begin
         if (hit(i_addr, ADDR_NEG_SUSTAIN)) next_neg_sustain = i_wdata;
         if (hit(i_addr, ADDR_BRAKE_TIME))  next_brake_time  = i_wdata;
         if (hit(i_addr, ADDR_FULL_SCALE))  next_full_scale  = i_wdata;
         if (hit(i_addr, ADDR_PEAK_LIMIT))  next_peak_limit  = i_wdata;
         if (hit(i_addr, ADDR_LOSS_TRIM))   next_loss_trim   = i_wdata;
         if (hit(i_addr, ADDR_FB_GAIN))     next_fb_gain     = i_wdata;
      end
      // Calibration result wins over a host write in the same cycle
      if (i_cal_done) begin
         next_loss_trim = i_cal_comp;                 // R11 R13
         next_fb_gain   = i_cal_gain;                 // R14
      end
   end

   // Register file flops
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         neg_sustain <= RST_NEG_SUSTAIN;
         brake_time  <= RST_BRAKE_TIME;
         full_scale  <= RST_FULL_SCALE;               // R6
         peak_limit  <= RST_PEAK_LIMIT;
         loss_trim   <= RST_LOSS_TRIM;                // R11
         fb_gain     <= RST_FB_GAIN;                  // R14
      end else begin
         neg_sustain <= next_neg_sustain;
         brake_time  <= next_brake_time;
         full_scale  <= next_full_scale;
         peak_limit  <= next_peak_limit;
         loss_trim   <= next_loss_trim;
         fb_gain     <= next_fb_gain;
      end
   end

   // ==========================================================
   // Playback snapshot of offsets and limits
   always_comb begin
      next_snap_snt   = snap_snt;
      next_snap_brt   = snap_brt;
      next_snap_full  = snap_full;
      next_snap_limit = snap_limit;
      next_snap_trim  = snap_trim;
      next_snap_gain  = snap_gain;
      if (i_play_start) begin
         next_snap_snt   = neg_sustain;               // R15
         next_snap_brt   = brake_time;
         next_snap_full  = full_scale;
         next_snap_limit = peak_limit;
         next_snap_trim  = loss_trim;
         next_snap_gain  = fb_gain;
      end
   end

   // Snapshot flops
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         snap_snt   <= RST_NEG_SUSTAIN;
         snap_brt   <= RST_BRAKE_TIME;
         snap_full  <= RST_FULL_SCALE;
         snap_limit <= RST_PEAK_LIMIT;
         snap_trim  <= RST_LOSS_TRIM;
         snap_gain  <= RST_FB_GAIN;
      end else begin
         snap_snt   <= next_snap_snt;
         snap_brt   <= next_snap_brt;
         snap_full  <= next_snap_full;
         snap_limit <= next_snap_limit;
         snap_trim  <= next_snap_trim;
         snap_gain  <= next_snap_gain;
      end
   end

   // ==========================================================
   // Arithmetic fed from the snapshot
   assign calc_bus.level       = i_level;
   assign calc_bus.wave_max    = i_wave_max;
   assign calc_bus.wave_min    = i_wave_min;
   assign calc_bus.closed_loop = i_closed_loop;
   assign calc_bus.auto_phase  = i_auto_phase;
   assign calc_bus.demand      = i_demand;
   assign calc_bus.tick_period = i_tick_period;
   assign calc_bus.neg_sustain = snap_snt;
   assign calc_bus.brake_time  = snap_brt;
   assign calc_bus.full_scale  = snap_full;
   assign calc_bus.peak_limit  = snap_limit;
   assign calc_bus.loss_trim   = snap_trim;

   haptic_wave_calc u_calc (
      .c (calc_bus.calc)
   );

   // ==========================================================
   // Read mux and output registers
   always_comb begin
      next_rdata       = o_rdata;
      next_seg_kind    = calc_bus.seg_kind;
      next_time_adj    = calc_bus.time_adj;
      next_drive_level = calc_bus.drive_level;
      if (i_rd_en) begin
         next_rdata = RDATA_UNMAPPED;
         if (hit(i_addr, ADDR_NEG_SUSTAIN)) next_rdata = neg_sustain;
         if (hit(i_addr, ADDR_BRAKE_TIME))  next_rdata = brake_time;
         if (hit(i_addr, ADDR_FULL_SCALE))  next_rdata = full_scale;
         if (hit(i_addr, ADDR_PEAK_LIMIT))  next_rdata = peak_limit;
         if (hit(i_addr, ADDR_LOSS_TRIM))   next_rdata = loss_trim;
         if (hit(i_addr, ADDR_FB_GAIN))     next_rdata = fb_gain;
      end
   end

   // Output flops
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata         <= RDATA_UNMAPPED;
         o_seg_kind      <= SEG_OTHER;
         o_time_adj_ms   <= '0;
         o_drive_level   <= '0;
         o_full_scale    <= RST_FULL_SCALE;
         o_feedback_gain <= RST_FB_GAIN;
         o_loss_trim     <= RST_LOSS_TRIM;
      end else begin
         o_rdata         <= next_rdata;
         o_seg_kind      <= next_seg_kind;
         o_time_adj_ms   <= next_time_adj;
         o_drive_level   <= next_drive_level;
         o_full_scale    <= snap_full;               // R6
         o_feedback_gain <= snap_gain;               // R14
         o_loss_trim     <= snap_trim;               // R12
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_wr_snt;
      i_wr_en && i_addr == ADDR_NEG_SUSTAIN;
   endsequence
   sequence s_rd_snt;
      i_rd_en && !i_wr_en && i_addr == ADDR_NEG_SUSTAIN;
   endsequence
   sequence s_brake_lvl;
      i_level < 0 && i_level == i_wave_min && i_level != i_wave_max;
   endsequence

   AST_SNT_RW: assert property (s_wr_snt ##1 s_rd_snt |=>   // R1
      o_rdata == $past(i_wdata, 2))
      else $error("offset readback wrong");
   AST_NEG_CLASS: assert property ((i_level < 0 && i_level != i_wave_max // R2
      && i_level != i_wave_min) |=> o_seg_kind == SEG_NEG_SUSTAIN
      && o_time_adj_ms == $signed($past(snap_snt))
      * $signed({1'b0, $past(i_tick_period)}))
      else $error("negative sustain not applied");
   AST_BRAKE_CLASS: assert property (s_brake_lvl |=>          // R4
      o_seg_kind == SEG_BRAKE)
      else $error("brake segment missed");
   AST_BRAKE_OPEN: assert property (s_brake_lvl ##0 !i_closed_loop // R3
      && !i_play_start |=> o_time_adj_ms == $signed(snap_brt)
      * $signed({1'b0, $past(i_tick_period)}))
      else $error("brake offset wrong");
   AST_BRAKE_CLOSED: assert property (s_brake_lvl ##0 i_closed_loop // R5
      |=> o_time_adj_ms == 0)
      else $error("brake offset used in closed loop");
   AST_FULL_CAP: assert property (i_closed_loop && !i_auto_phase  // R6
      && !i_play_start |=> o_drive_level <= snap_full)
      else $error("drive above full scale");
   AST_PEAK_CAP: assert property (i_closed_loop && i_auto_phase   // R10
      && !i_play_start |=> o_drive_level <= snap_limit)
      else $error("drive above peak limit");
   AST_CAL_STORE: assert property (i_cal_done |=>                 // R11
      loss_trim == $past(i_cal_comp) && fb_gain == $past(i_cal_gain))
      else $error("calibration result lost");
   AST_SNAP_HOLD: assert property (!i_play_start |=>             // R15
      $stable(snap_snt) && $stable(snap_limit) && $stable(snap_brt))
      else $error("snapshot changed during playback");
   AST_SNAP_TAKE: assert property (i_play_start |=>               // R15
      snap_full == $past(full_scale) && snap_gain == $past(fb_gain))
      else $error("snapshot not taken");

   // ==========================================================
   // Drive path and readback checks
   sequence s_open_fit;
      !i_closed_loop && !i_play_start
      && ({1'b0, i_demand} + {1'b0, snap_trim}) <= DRIVE_SAT;
   endsequence
   sequence s_open_over;
      !i_closed_loop && !i_play_start
      && ({1'b0, i_demand} + {1'b0, snap_trim}) > DRIVE_SAT;
   endsequence
   sequence s_rd_trim;
      i_rd_en && i_addr == ADDR_LOSS_TRIM;
   endsequence
   sequence s_rd_gain;
      i_rd_en && i_addr == ADDR_FB_GAIN;
   endsequence

   AST_OPEN_SUM: assert property (s_open_fit |=>             // R12
      o_drive_level == 8'($past(i_demand) + $past(snap_trim)))
      else $error("loss trim not added");
   AST_OPEN_SAT: assert property (s_open_over |=>            // R12
      o_drive_level == DRIVE_SAT[7:0])
      else $error("drive not saturated");
   AST_OVER_CLASS: assert property (i_level == i_wave_max |=> // R2
      o_seg_kind == SEG_OVERDRIVE && o_time_adj_ms == 0)
      else $error("overdrive level misclassed");
   AST_OTHER_CLASS: assert property (i_level >= 0            // R2
      && i_level != i_wave_max |=> o_seg_kind == SEG_OTHER
      && o_time_adj_ms == 0)
      else $error("positive level misclassed");
   AST_GAIN_WR: assert property (i_wr_en && !i_cal_done     // R14
      && i_addr == ADDR_FB_GAIN |=> fb_gain == $past(i_wdata))
      else $error("gain write lost");
   AST_TRIM_RD: assert property (s_rd_trim |=>               // R11
      o_rdata == $past(loss_trim))
      else $error("loss trim readback wrong");
   AST_GAIN_RD: assert property (s_rd_gain |=>               // R14
      o_rdata == $past(fb_gain))
      else $error("gain readback wrong");
   AST_OUT_SNAP: assert property (i_rstn |=>                 // R15
      o_full_scale == $past(snap_full) && o_loss_trim == $past(snap_trim)
      && o_feedback_gain == $past(snap_gain))
      else $error("snapshot not shown");

endmodule : haptic_waveform_calib_regs

// File: verilog/haptic_calib_pkg.sv
// Constants and types shared by the haptic calibration register bank
package haptic_calib_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] ADDR_NEG_SUSTAIN = 8'h1C;
   localparam logic [7:0] ADDR_BRAKE_TIME  = 8'h1D;
   localparam logic [7:0] ADDR_FULL_SCALE  = 8'h1F;
   localparam logic [7:0] ADDR_PEAK_LIMIT  = 8'h20;
   localparam logic [7:0] ADDR_LOSS_TRIM   = 8'h21;
   localparam logic [7:0] ADDR_FB_GAIN     = 8'h22;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_NEG_SUSTAIN  = 8'h00;
   localparam logic [7:0] RST_BRAKE_TIME   = 8'h00;
   localparam logic [7:0] RST_FULL_SCALE   = 8'h3F;
   localparam logic [7:0] RST_PEAK_LIMIT   = 8'hFF;
   localparam logic [7:0] RST_LOSS_TRIM    = 8'h0D;
   localparam logic [7:0] RST_FB_GAIN      = 8'h6D;
   localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

   // ==========================================================
   // Widths and saturation limits
   localparam int         DATA_W           = 8;
   localparam int         TIME_W           = 17;
   localparam logic [8:0] DRIVE_SAT        = 9'h0FF;

   // ==========================================================
   // Waveform segment classes
   typedef enum logic [1:0] {
      SEG_OTHER       = 2'b00,
      SEG_OVERDRIVE   = 2'b01,
      SEG_NEG_SUSTAIN = 2'b10,
      SEG_BRAKE       = 2'b11
   } seg_kind_e;

endpackage : haptic_calib_pkg

// File: verilog/haptic_calc_if.sv
// Interface between the register bank and its playback arithmetic
`timescale 1ns/1ns
interface haptic_calc_if;
   import haptic_calib_pkg::*;

   logic signed [7:0]        level;
   logic signed [7:0]        wave_max;
   logic signed [7:0]        wave_min;
   logic                     closed_loop;
   logic                     auto_phase;
   logic        [7:0]        demand;
   logic        [7:0]        tick_period;
   logic        [7:0]        neg_sustain;
   logic        [7:0]        brake_time;
   logic        [7:0]        full_scale;
   logic        [7:0]        peak_limit;
   logic        [7:0]        loss_trim;
   seg_kind_e                seg_kind;
   logic signed [TIME_W-1:0] time_adj;
   logic        [7:0]        drive_level;

   // Arithmetic side
   modport calc (
      input  level, wave_max, wave_min, closed_loop, auto_phase, demand,
      input  tick_period, neg_sustain, brake_time, full_scale,
      input  peak_limit, loss_trim,
      output seg_kind, time_adj, drive_level
   );

   // Register bank side
   modport bank (
      output level, wave_max, wave_min, closed_loop, auto_phase, demand,
      output tick_period, neg_sustain, brake_time, full_scale,
      output peak_limit, loss_trim,
      input  seg_kind, time_adj, drive_level
   );

endinterface : haptic_calc_if

// File: verilog/haptic_wave_calc.sv
// Segment classification, time offset and drive limiting arithmetic
`timescale 1ns/1ns
module haptic_wave_calc (
   haptic_calc_if.calc c
);
   import haptic_calib_pkg::*;

   logic signed [TIME_W-1:0] next_prod_snt;
   logic signed [TIME_W-1:0] next_prod_brt;
   logic        [8:0]        next_comp;
   logic        [7:0]        next_limit;

   // ==========================================================
   // Offset products: signed register times tick period
   always_comb begin
      next_prod_snt = $signed(c.neg_sustain) * $signed({1'b0, c.tick_period});
      next_prod_brt = $signed(c.brake_time) * $signed({1'b0, c.tick_period});
   end

   // ==========================================================
   // Segment class and offset selection
   always_comb begin
      c.seg_kind = SEG_OTHER;
      c.time_adj = '0;
      if (c.level == c.wave_max) begin
         c.seg_kind = SEG_OVERDRIVE;
      end else if (c.level < 0 && c.level == c.wave_min) begin
         c.seg_kind = SEG_BRAKE;                                 // R4
         if (!c.closed_loop) begin
            c.time_adj = next_prod_brt;                          // R3
         end                                                     // R5
      end else if (c.level < 0) begin
         c.seg_kind = SEG_NEG_SUSTAIN;                           // R2
         c.time_adj = next_prod_snt;                             // R1
      end
   end

   // ==========================================================
   // Loss compensation and output limiting
   always_comb begin
      next_comp = {1'b0, c.demand} + {1'b0, c.loss_trim};      // R12
      if (next_comp > DRIVE_SAT) begin
         next_comp = DRIVE_SAT;
      end
      if (!c.closed_loop) begin
         next_limit = DRIVE_SAT[7:0];
      end else if (c.auto_phase) begin
         next_limit = c.peak_limit;                              // R9
      end else begin
         next_limit = c.full_scale;                              // R6
      end
      if (next_comp[7:0] > next_limit) begin
         c.drive_level = next_limit;                             // R10
      end else begin
         c.drive_level = next_comp[7:0];
      end
   end

endmodule : haptic_wave_calc

// File: verif/haptic_host_model.sv
// Host controller model on the register byte port
`timescale 1ns/1ns
module haptic_host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr_en,
   output logic            o_rd_en,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata
);
   // ==========================================
   // Bus idle at time zero
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 8'h00;
      o_wdata = 8'h00;
   end

   // One byte write; released lines flip so stale data never lingers
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_addr  = a;
      o_wdata = d;
      o_wr_en = 1'b1;
      @(posedge i_clk);
      #1;
      o_wr_en = 1'b0;
      o_addr  = ~a;
      o_wdata = ~d;
   endtask : write_reg

   // One byte read; data is taken one edge after the strobe
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_addr  = a;
      o_rd_en = 1'b1;
      @(posedge i_clk);
      #1;
      d       = i_rdata;
      o_rd_en = 1'b0;
      o_addr  = ~a;
   endtask : read_reg

   // Write, then read back on the very next edge
   task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                             output logic [7:0] q);
      @(posedge i_clk);
      #1;
      o_addr  = a;
      o_wdata = d;
      o_wr_en = 1'b1;
      @(posedge i_clk);
      #1;
      o_wr_en = 1'b0;
      o_rd_en = 1'b1;
      @(posedge i_clk);
      #1;
      q       = i_rdata;
      o_rd_en = 1'b0;
      o_addr  = ~a;
      o_wdata = ~d;
   endtask : write_read

   // Rated level goes in before every calibration run
   task automatic prepare_cal(input logic [7:0] rated);
      write_reg(haptic_calib_pkg::ADDR_FULL_SCALE, rated);
   endtask : prepare_cal
endmodule : haptic_host_model

// File: verif/tb.sv
// Self-checking bench for the haptic calibration register bank
`timescale 1ns/1ns
module tb;
   import haptic_calib_pkg::*;
   // ==========================================
   // Signals
   logic                     clk;
   logic                     rstn;
   logic                     wr_en;
   logic                     rd_en;
   logic [7:0]               addr;
   logic [7:0]               wdata;
   logic                     play_start;
   logic                     closed_loop;
   logic                     auto_phase;
   logic signed [7:0]        level;
   logic signed [7:0]        wave_max;
   logic signed [7:0]        wave_min;
   logic [7:0]               demand;
   logic [7:0]               tick_period;
   logic                     cal_done;
   logic [7:0]               cal_comp;
   logic [7:0]               cal_gain;
   logic [7:0]               rdata;
   seg_kind_e                seg_kind;
   logic signed [TIME_W-1:0] time_adj;
   logic [7:0]               drive;
   logic [7:0]               full_scale;
   logic [7:0]               fb_gain;
   logic [7:0]               loss_trim;
   int                       n_mismatch = 0;
   int                       cmp_count = 0;
   int                       cycles = 0;
   logic [7:0] adr_tab [6] = '{ADDR_NEG_SUSTAIN, ADDR_BRAKE_TIME,
      ADDR_FULL_SCALE, ADDR_PEAK_LIMIT, ADDR_LOSS_TRIM, ADDR_FB_GAIN};
   logic [7:0] rst_tab [6] = '{RST_NEG_SUSTAIN, RST_BRAKE_TIME,
      RST_FULL_SCALE, RST_PEAK_LIMIT, RST_LOSS_TRIM, RST_FB_GAIN};

   // ==========================================
   // Instances
   haptic_host_model haptic_host_model_inst (.i_clk(clk), .i_rdata(rdata),
      .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
   haptic_waveform_calib_regs haptic_waveform_calib_regs_inst (
      .i_clk(clk), .i_rstn(rstn), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .i_addr(addr), .i_wdata(wdata), .i_play_start(play_start),
      .i_closed_loop(closed_loop), .i_auto_phase(auto_phase),
      .i_level(level), .i_wave_max(wave_max), .i_wave_min(wave_min),
      .i_demand(demand), .i_tick_period(tick_period),
      .i_cal_done(cal_done), .i_cal_comp(cal_comp), .i_cal_gain(cal_gain),
      .o_rdata(rdata), .o_seg_kind(seg_kind), .o_time_adj_ms(time_adj),
      .o_drive_level(drive), .o_full_scale(full_scale),
      .o_feedback_gain(fb_gain), .o_loss_trim(loss_trim));

   // ==========================================
   // Clock and hang guard
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         test_done();
      end
   end

   // ==========================================
   // Compare and helper tasks
   task automatic report(input string what);
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, what);
   endtask : report
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) report($sformatf("byte %h not %h", got, exp));
   endtask : chk8
   task automatic chk_t(input logic signed [TIME_W-1:0] got, input int e);
      cmp_count++;
      if (got !== TIME_W'(e)) report($sformatf("offset %0d not %0d", got, e));
   endtask : chk_t
   task automatic chk_seg(input seg_kind_e got, input seg_kind_e exp);
      cmp_count++;
      if (got !== exp) report($sformatf("class %0d not %0d", got, exp));
   endtask : chk_seg
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      haptic_host_model_inst.read_reg(a, d);
      chk8(d, exp);
   endtask : rd_chk
   task automatic play();
      step();
      play_start = 1'b1;
      step();
      play_start = 1'b0;
   endtask : play
   // Present one sample, outputs settle one edge later
   task automatic eval(input logic signed [7:0] lv, input logic cl,
                       input logic ap, input logic [7:0] dem);
      level       = lv;
      closed_loop = cl;
      auto_phase  = ap;
      demand      = dem;
      step();
   endtask : eval

   // ==========================================
   // Scenarios
   task automatic t_regs();
      logic [7:0] q;
      for (int i = 0; i < 6; i++) rd_chk(adr_tab[i], rst_tab[i]);
      rd_chk(8'h1E, RDATA_UNMAPPED);
      for (int i = 0; i < 6; i++)
         haptic_host_model_inst.write_reg(adr_tab[i], 8'hA5 ^ 8'(i));
      haptic_host_model_inst.write_reg(8'h1E, 8'h5A);
      for (int i = 0; i < 6; i++) rd_chk(adr_tab[i], 8'hA5 ^ 8'(i));
      rd_chk(8'h1E, RDATA_UNMAPPED);
      haptic_host_model_inst.write_read(ADDR_NEG_SUSTAIN, 8'h3C, q);
      chk8(q, 8'h3C);
      chk8(full_scale, RST_FULL_SCALE);
      chk8(fb_gain, RST_FB_GAIN);
      chk8(loss_trim, RST_LOSS_TRIM);
   endtask : t_regs

   task automatic t_seg();
      haptic_host_model_inst.write_reg(ADDR_NEG_SUSTAIN, 8'hFE);
      haptic_host_model_inst.write_reg(ADDR_BRAKE_TIME, 8'h03);
      play();
      wave_max = 8'sd100;
      wave_min = -8'sd90;
      eval(8'sd100, 1'b0, 1'b0, 8'h00);
      chk_seg(seg_kind, SEG_OVERDRIVE);
      eval(-8'sd40, 1'b0, 1'b0, 8'h00);
      chk_seg(seg_kind, SEG_NEG_SUSTAIN);
      chk_t(time_adj, -2 * 10);
      eval(-8'sd90, 1'b0, 1'b0, 8'h00);
      chk_seg(seg_kind, SEG_BRAKE);
      chk_t(time_adj, 3 * 10);
      eval(-8'sd90, 1'b1, 1'b0, 8'h00);
      chk_t(time_adj, 0);
      eval(8'sd20, 1'b0, 1'b0, 8'h00);
      chk_seg(seg_kind, SEG_OTHER);
      wave_max = -8'sd10;
      eval(-8'sd10, 1'b0, 1'b0, 8'h00);
      chk_seg(seg_kind, SEG_OVERDRIVE);
      wave_max = 8'sd100;
   endtask : t_seg

   task automatic t_drive();
      haptic_host_model_inst.write_reg(ADDR_FULL_SCALE, 8'h50);
      haptic_host_model_inst.write_reg(ADDR_PEAK_LIMIT, 8'h90);
      haptic_host_model_inst.write_reg(ADDR_LOSS_TRIM, 8'h10);
      play();
      eval(8'sd0, 1'b0, 1'b0, 8'h60);
      chk8(drive, 8'h70);
      chk8(full_scale, 8'h50);
      eval(8'sd0, 1'b1, 1'b0, 8'h60);
      chk8(drive, 8'h50);
      eval(8'sd0, 1'b1, 1'b1, 8'h60);
      chk8(drive, 8'h70);
      eval(8'sd0, 1'b1, 1'b1, 8'hA0);
      chk8(drive, 8'h90);
      eval(8'sd0, 1'b0, 1'b0, 8'hF8);
      chk8(drive, 8'hFF);
   endtask : t_drive

   task automatic t_snap();
      haptic_host_model_inst.write_reg(ADDR_NEG_SUSTAIN, 8'h05);
      eval(-8'sd40, 1'b0, 1'b0, 8'h00);
      chk_t(time_adj, -2 * 10);
      play();
      eval(-8'sd40, 1'b0, 1'b0, 8'h00);
      chk_t(time_adj, 5 * 10);
   endtask : t_snap

   task automatic t_cal();
      haptic_host_model_inst.prepare_cal(8'h48);
      step();
      cal_done = 1'b1;
      cal_comp = 8'h22;
      cal_gain = 8'h44;
      step();
      cal_done = 1'b0;
      cal_comp = 8'hDD;
      cal_gain = 8'hBB;
      rd_chk(ADDR_LOSS_TRIM, 8'h22);
      rd_chk(ADDR_FB_GAIN, 8'h44);
      chk8(loss_trim, 8'h10);
      play();
      eval(8'sd0, 1'b0, 1'b0, 8'h10);
      chk8(loss_trim, 8'h22);
      chk8(fb_gain, 8'h44);
      chk8(drive, 8'h32);
   endtask : t_cal

   // ==========================================
   // Verdict and main sequence
   task automatic test_done();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      play_start = 1'b0;
      closed_loop = 1'b0;
      auto_phase = 1'b0;
      level = 8'sd0;
      wave_max = 8'sd0;
      wave_min = 8'sd0;
      demand = 8'h00;
      tick_period = 8'd10;
      cal_done = 1'b0;
      cal_comp = 8'h00;
      cal_gain = 8'h00;
      repeat (5) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_regs();
      t_seg();
      t_drive();
      t_snap();
      t_cal();
      test_done();
   end
endmodule : tb
